// >>> logic/load_reg_pkg.sv
`default_nettype none
package load_reg_pkg;

  localparam int unsigned LOAD_W        = 10;
  localparam int unsigned SCALE_W       = 5;
  localparam int unsigned OFFSET_W      = 7;
  localparam int unsigned CODE4_W       = 4;
  localparam int unsigned CODE2_W       = 2;
  localparam int unsigned SUM_W         = 12;
  localparam int unsigned DN_CNT_W      = 6;

  // band codes are scaled by 32
  localparam int unsigned BAND_SHIFT    = 5;
  // one offset step moves the reading by 8
  localparam int unsigned OFFSET_SHIFT  = 3;
  // last count of the four-reading load filter and its divide shift
  localparam logic [1:0]  FILTER_LAST   = 2'h3;
  localparam int unsigned FILTER_SHIFT  = 2;

  localparam logic [LOAD_W-1:0]  LOAD_MAX     = 10'h3ff;
  localparam logic [LOAD_W-1:0]  LOAD_RESET   = 10'h3ff;
  localparam logic [SCALE_W-1:0] SCALE_RESET  = 5'h00;
  localparam logic [SUM_W-1:0]   SUM_RESET    = 12'h000;

  localparam logic [3:0] INC_STEP_0 = 4'h1;
  localparam logic [3:0] INC_STEP_1 = 4'h2;
  localparam logic [3:0] INC_STEP_2 = 4'h4;
  localparam logic [3:0] INC_STEP_3 = 4'h8;

  localparam logic [DN_CNT_W-1:0] DEC_NEED_0 = 6'h20;
  localparam logic [DN_CNT_W-1:0] DEC_NEED_1 = 6'h08;
  localparam logic [DN_CNT_W-1:0] DEC_NEED_2 = 6'h02;
  localparam logic [DN_CNT_W-1:0] DEC_NEED_3 = 6'h01;

  function automatic logic [3:0] inc_step(input logic [1:0] code);
    unique case (code)
      2'h0: inc_step = INC_STEP_0;
      2'h1: inc_step = INC_STEP_1;
      2'h2: inc_step = INC_STEP_2;
      2'h3: inc_step = INC_STEP_3;
    endcase
  endfunction : inc_step

  function automatic logic [DN_CNT_W-1:0] dec_need(input logic [1:0] code);
    unique case (code)
      2'h0: dec_need = DEC_NEED_0;
      2'h1: dec_need = DEC_NEED_1;
      2'h2: dec_need = DEC_NEED_2;
      2'h3: dec_need = DEC_NEED_3;
    endcase
  endfunction : dec_need

  // lowest code: (cs+1)/2 or (cs+1)/4 thirty-seconds, at least code 0
  function automatic logic [SCALE_W-1:0] min_scale(
    input logic [SCALE_W-1:0] cs,
    input logic               quarter
  );
    logic [SCALE_W:0] part;
    part = quarter ? ({1'b0, cs} + 6'h01) >> 2 : ({1'b0, cs} + 6'h01) >> 1;
    min_scale = (part == 6'h00) ? 5'h00 : 5'(part - 6'h01);
  endfunction : min_scale

  function automatic logic [LOAD_W-1:0] apply_offset(
    input logic [LOAD_W-1:0]   raw,
    input logic [OFFSET_W-1:0] ofs
  );
    logic signed [SUM_W-1:0] term;
    logic signed [SUM_W-1:0] sum;
    term = $signed({{5{ofs[6]}}, ofs}) <<< OFFSET_SHIFT;
    sum  = $signed({2'b00, raw}) + term;
    if (sum < 0)
      apply_offset = 10'h000;
    else if (sum > $signed({2'b00, LOAD_MAX}))
      apply_offset = LOAD_MAX;
    else
      apply_offset = sum[LOAD_W-1:0];
  endfunction : apply_offset

endpackage : load_reg_pkg
`default_nettype wire

// >>> logic/load_filter.sv
`timescale 1ns/1ps
`default_nettype none
module load_filter
  import load_reg_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              step_strobe,
  input  wire logic [LOAD_W-1:0] sample,
  input  wire logic              filter_enable,
  output var  logic [LOAD_W-1:0] avg_q,
  output var  logic              avg_valid_q
);

  logic [1:0]       cnt_q;
  logic [SUM_W-1:0] sum_q;
  logic [SUM_W-1:0] sum_d;

  assign sum_d = sum_q + {2'b00, sample};

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_q <= 2'h0;
      sum_q <= SUM_RESET;
    end else if (!filter_enable) begin
      cnt_q <= 2'h0;
      sum_q <= SUM_RESET;
    end else if (step_strobe) begin
      cnt_q <= cnt_q + 2'h1;
      sum_q <= (cnt_q == FILTER_LAST) ? SUM_RESET : sum_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      avg_q       <= LOAD_RESET;
      avg_valid_q <= 1'b0;
    end else if (step_strobe && !filter_enable) begin
      avg_q       <= sample; // RQ1
      avg_valid_q <= 1'b1;
    end else if (step_strobe && cnt_q == FILTER_LAST) begin
      avg_q       <= sum_d[LOAD_W+1:FILTER_SHIFT]; // RQ2
      avg_valid_q <= 1'b1;
    end else begin
      avg_valid_q <= 1'b0;
    end
  end

  a_filter_quarter : assert property (@(posedge mclk) disable iff (reset)
    filter_enable && step_strobe && cnt_q != FILTER_LAST |=> !avg_valid_q) // RQ2
    else $error("filtered result published before fourth step");

  a_filter_avg : assert property (@(posedge mclk) disable iff (reset)
    filter_enable && step_strobe && cnt_q == FILTER_LAST
    |=> avg_valid_q && avg_q == LOAD_W'($past(sum_d) >> FILTER_SHIFT)) // RQ2
    else $error("filtered result missing or not the average");

endmodule : load_filter
`default_nettype wire

// >>> logic/load_adaptive_current_regulator.sv
// How it works
// [RQ1] unfiltered, a new load reading is published on every full step
// [RQ2] filter on: four readings averaged, one result per four full steps
// [RQ3] signed offset -64..+63 shifts the reading; positive means less sensitive
// [RQ4] reading rises with lighter load; zero means maximum load
// [RQ5] stall output is high while the reading is zero
// [RQ6] host tunes the offset starting at zero, by observed stall behaviour
// [RQ7] lower threshold is lower band code times 32; below it current rises
// [RQ8] lower band code zero switches adaptive regulation off
// [RQ9] upper threshold is (lower band + band width + 1) times 32
// [RQ10] each reading below lower threshold adds 1, 2, 4 or 8
// [RQ11] 32, 8, 2 or 1 readings above upper threshold remove one step
// [RQ12] current never drops below half or quarter of the scale setting
// [RQ13] actual scale 0..31 reported, bounded by setting and minimum
// [RQ14] host uses fixed current with standstill reduction at low speed
// [RQ15] while regulation is off, actual scale follows the scale setting
`timescale 1ns/1ps
`default_nettype none
module load_adaptive_current_regulator
  import load_reg_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic                full_step_strobe,
  input  wire logic [LOAD_W-1:0]   raw_load,
  input  wire logic [OFFSET_W-1:0] load_threshold_offset,
  input  wire logic                load_filter_enable,
  input  wire logic [CODE4_W-1:0]  lower_band_code,
  input  wire logic [CODE4_W-1:0]  band_width_code,
  input  wire logic [CODE2_W-1:0]  increment_step_code,
  input  wire logic [CODE2_W-1:0]  decrement_rate_code,
  input  wire logic                min_current_code,
  input  wire logic [SCALE_W-1:0]  current_scale_setting,
  output var  logic [LOAD_W-1:0]   load_reading,
  output var  logic                load_reading_valid,
  output var  logic                stall_output,
  output var  logic [SCALE_W-1:0]  actual_current_scale
);

  logic [LOAD_W-1:0]   filt_q;
  logic                filt_valid_q;
  logic [LOAD_W-1:0]   load_reading_q;
  logic                load_reading_valid_q;
  logic                stall_q;
  logic [SCALE_W-1:0]  scale_q;
  logic [SCALE_W-1:0]  scale_d;
  logic [DN_CNT_W-1:0] dn_cnt_q;
  logic [DN_CNT_W-1:0] dn_cnt_d;
  logic [LOAD_W-1:0]   lower_thr;
  logic [LOAD_W-1:0]   upper_thr;
  logic [SCALE_W-1:0]  floor_scale;
  logic                regulate_on;
  logic                below_lower;
  logic                above_upper;
  logic                dec_hit;

  assign load_reading         = load_reading_q;
  assign load_reading_valid   = load_reading_valid_q;
  assign stall_output         = stall_q;
  assign actual_current_scale = scale_q;

  load_filter u_filter (
    .mclk          (mclk),
    .reset         (reset),
    .step_strobe   (full_step_strobe),
    .sample        (raw_load),
    .filter_enable (load_filter_enable),
    .avg_q         (filt_q),
    .avg_valid_q   (filt_valid_q)
  );

  // offset and saturation of the published reading
  always_ff @(posedge mclk) begin
    if (reset) begin
      load_reading_q       <= LOAD_RESET;
      load_reading_valid_q <= 1'b0;
    end else begin
      load_reading_valid_q <= filt_valid_q; // RQ1 RQ2
      if (filt_valid_q)
        load_reading_q <= apply_offset(filt_q, load_threshold_offset); // RQ3 RQ4
    end
  end

  always_ff @(posedge mclk) begin
    if (reset)
      stall_q <= 1'b0;
    else if (filt_valid_q)
      stall_q <= (apply_offset(filt_q, load_threshold_offset) == 10'h000); // RQ5
  end

  // thresholds
  assign lower_thr = {1'b0, lower_band_code, 5'h00}; // RQ7
  assign upper_thr = 10'(({1'b0, lower_band_code} + {1'b0, band_width_code}
                          + 5'h01) << BAND_SHIFT); // RQ9
  assign floor_scale = min_scale(current_scale_setting, min_current_code);
  assign regulate_on = (lower_band_code != 4'h0); // RQ8
  assign below_lower = load_reading_q < lower_thr;
  assign above_upper = load_reading_q > upper_thr;
  assign dec_hit     = (dn_cnt_q + 6'h01) >= dec_need(decrement_rate_code);

  always_comb begin
    dn_cnt_d = dn_cnt_q;
    if (!regulate_on)
      dn_cnt_d = 6'h00;
    else if (load_reading_valid_q && above_upper)
      dn_cnt_d = dec_hit ? 6'h00 : dn_cnt_q + 6'h01; // RQ11
    else if (load_reading_valid_q)
      dn_cnt_d = 6'h00;
  end

  always_comb begin
    logic [SCALE_W:0] wide;
    wide = {1'b0, scale_q};
    if (load_reading_valid_q && below_lower)
      wide = {1'b0, scale_q} + {2'b00, inc_step(increment_step_code)}; // RQ10
    else if (load_reading_valid_q && above_upper && dec_hit
             && scale_q > floor_scale)
      wide = {1'b0, scale_q} - 6'h01; // RQ11
    if (wide > {1'b0, current_scale_setting})
      wide = {1'b0, current_scale_setting}; // RQ13
    if (wide < {1'b0, floor_scale})
      wide = {1'b0, floor_scale}; // RQ12
    scale_d = wide[SCALE_W-1:0];
  end

  always_ff @(posedge mclk) begin
    if (reset)
      dn_cnt_q <= 6'h00;
    else
      dn_cnt_q <= dn_cnt_d;
  end

  always_ff @(posedge mclk) begin
    if (reset)
      scale_q <= SCALE_RESET;
    else if (!regulate_on)
      scale_q <= current_scale_setting; // RQ15 RQ8
    else
      scale_q <= scale_d; // RQ13
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_unfiltered_rate : assert property (
    !load_filter_enable && full_step_strobe |-> ##2 load_reading_valid) // RQ1
    else $error("unfiltered reading not published two cycles after step");

  a_offset_applied : assert property (
    filt_valid_q |=> load_reading
      == apply_offset($past(filt_q), $past(load_threshold_offset))) // RQ3
    else $error("reading does not carry the offset");

  a_stall_on_zero : assert property (
    load_reading_valid |-> stall_output == (load_reading == 10'h000)) // RQ5
    else $error("stall output disagrees with zero reading");

  a_disabled_follow : assert property (
    lower_band_code == 4'h0 |=>
      actual_current_scale == $past(current_scale_setting)) // RQ15
    else $error("scale does not follow setting while regulation off");

  a_scale_ceiling : assert property (
    $stable(current_scale_setting) [*2] |->
      actual_current_scale <= current_scale_setting) // RQ13
    else $error("actual scale above setting");

  // first edge after reset still shows the reset value of the scale
  a_scale_floor : assert property (
    $stable(current_scale_setting) && $stable(min_current_code)
      && $past(current_scale_setting, 2) == current_scale_setting
      && $past(min_current_code, 2) == min_current_code
      && !$past(reset) |->
      actual_current_scale >= floor_scale) // RQ12
    else $error("actual scale below minimum");

  a_increment_step : assert property (
    load_reading_valid && lower_band_code != 4'h0
      && load_reading < {1'b0, lower_band_code, 5'h00}
      && actual_current_scale >= floor_scale
      && ({1'b0, actual_current_scale}
          + {2'b00, inc_step(increment_step_code)})
         <= {1'b0, current_scale_setting}
    |=> actual_current_scale == $past(actual_current_scale)
        + 5'(inc_step($past(increment_step_code)))) // RQ10 RQ7
    else $error("increment step not applied");

  a_single_decrement : assert property (
    load_reading_valid && lower_band_code != 4'h0
      && decrement_rate_code == 2'h3 && load_reading > upper_thr
      && actual_current_scale > floor_scale
      && actual_current_scale <= current_scale_setting
    |=> actual_current_scale == $past(actual_current_scale) - 5'h01) // RQ11 RQ9
    else $error("decrement after one high reading missing");

  a_slow_decrement : assert property (
    load_reading_valid && lower_band_code != 4'h0
      && decrement_rate_code == 2'h0 && load_reading > upper_thr
      && dn_cnt_q < 6'h1e
      && actual_current_scale >= floor_scale
      && actual_current_scale <= current_scale_setting
      && $stable(current_scale_setting)
    |=> actual_current_scale == $past(actual_current_scale)) // RQ11
    else $error("decrement before thirty-two high readings");

  a_band_hold : assert property (
    load_reading_valid && lower_band_code != 4'h0
      && load_reading >= lower_thr && load_reading <= upper_thr
      && actual_current_scale >= floor_scale
      && actual_current_scale <= current_scale_setting
    |=> actual_current_scale == $past(actual_current_scale)) // RQ9
    else $error("scale changed inside the band");

endmodule : load_adaptive_current_regulator
`default_nettype wire

// >>> tb/motor_step_model.sv
`timescale 1ns/1ps
`default_nettype none
module motor_step_model
  import load_reg_pkg::*;
(
  input  wire logic              mclk,
  output var  logic              full_step_strobe,
  output var  logic [LOAD_W-1:0] raw_load
);
  initial begin
    full_step_strobe = 1'b0;
    raw_load         = 10'h155;
  end

  // one full step; the load line drifts once the strobe is gone
  task automatic full_step(input logic [LOAD_W-1:0] raw);
    @(negedge mclk);
    full_step_strobe = 1'b1;
    raw_load         = raw;
    @(negedge mclk);
    full_step_strobe = 1'b0;
    raw_load         = ~raw;
  endtask : full_step
endmodule : motor_step_model
`default_nettype wire

// >>> tb/load_adaptive_current_regulator_test.sv
`timescale 1ns/1ps
`default_nettype none
module load_adaptive_current_regulator_test;
  import load_reg_pkg::*;
  localparam int SETTING = 20;
  logic                mclk;
  logic                reset;
  logic                full_step_strobe;
  logic [LOAD_W-1:0]   raw_load;
  logic [OFFSET_W-1:0] load_threshold_offset;
  logic                load_filter_enable;
  logic [CODE4_W-1:0]  lower_band_code;
  logic [CODE4_W-1:0]  band_width_code;
  logic [CODE2_W-1:0]  increment_step_code;
  logic [CODE2_W-1:0]  decrement_rate_code;
  logic                min_current_code;
  logic [SCALE_W-1:0]  current_scale_setting;
  logic [LOAD_W-1:0]   load_reading;
  logic                load_reading_valid;
  logic                stall_output;
  logic [SCALE_W-1:0]  actual_current_scale;
  int                  error_cnt = 0;
  int                  comparisons = 0;
  int                  cycles = 0;
  int                  expv;

  load_adaptive_current_regulator DUT (
    .mclk, .reset, .full_step_strobe, .raw_load, .load_threshold_offset,
    .load_filter_enable, .lower_band_code, .band_width_code,
    .increment_step_code, .decrement_rate_code, .min_current_code,
    .current_scale_setting, .load_reading, .load_reading_valid,
    .stall_output, .actual_current_scale
  );

  motor_step_model motor (.mclk, .full_step_strobe, .raw_load);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [LOAD_W-1:0] exp,
                       input logic [LOAD_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // valid stands one cycle, between the second and third edge after strobe
  task automatic step(input int raw, input logic vexp);
    motor.full_step(raw[LOAD_W-1:0]);
    @(negedge mclk);
    check("valid", {9'h000, vexp}, {9'h000, load_reading_valid});
    @(negedge mclk);
    check("valid end", 10'h000, {9'h000, load_reading_valid});
    @(negedge mclk);
  endtask : step

  task automatic t_reset(input logic [LOAD_W-1:0] scale_exp);
    reset = 1'b1;
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    check("reading", LOAD_MAX, load_reading);
    check("stall", 10'h000, {9'h000, stall_output});
    check("scale", scale_exp, {5'h00, actual_current_scale});
  endtask : t_reset

  task automatic reg_step(input int raw, input int exp);
    step(raw, 1'b1);
    check("scale", LOAD_W'(exp), {5'h00, actual_current_scale});
  endtask : reg_step

  task automatic t_offset();
    int raw[5] = '{200, 100, 1000, 300, 520};
    int ofs[5] = '{0, 63, 5, -64, -64};
    for (int i = 0; i < 5; i++) begin
      load_threshold_offset = OFFSET_W'(ofs[i]);
      expv = raw[i] + 8 * ofs[i];
      expv = expv < 0 ? 0 : (expv > 1023 ? 1023 : expv);
      step(raw[i], 1'b1);
      check("reading", LOAD_W'(expv), load_reading);
      check("stall", LOAD_W'(expv == 0), {9'h000, stall_output});
    end
    load_threshold_offset = 7'h00;
  endtask : t_offset

  task automatic t_filter();
    load_filter_enable = 1'b1;
    step(100, 1'b0);
    step(200, 1'b0);
    step(300, 1'b0);
    step(401, 1'b1);
    check("reading", 10'h0fa, load_reading);
    load_filter_enable = 1'b0;
  endtask : t_filter

  task automatic t_decrement();
    int need[4] = '{32, 8, 2, 1};
    expv = SETTING;
    lower_band_code = 4'h2;
    band_width_code = 4'h1;
    for (int c = 0; c < 4; c++) begin
      decrement_rate_code = CODE2_W'(c);
      for (int i = 1; i <= need[c]; i++) begin
        if (i == need[c]) expv--;
        reg_step(500, expv);
      end
    end
    reg_step(128, expv);
    expv--;
    reg_step(129, expv);
    reg_step(64, expv);
    increment_step_code = 2'h0;
    expv++;
    reg_step(63, expv);
  endtask : t_decrement

  task automatic t_floor_and_rise();
    int inc[4] = '{1, 2, 4, 8};
    for (int m = 0; m < 2; m++) begin
      min_current_code = m[0];
      for (int i = 0; i < 14; i++) begin
        expv = (expv - 1 < ((SETTING + 1) >> (m + 1)) - 1) ?
               ((SETTING + 1) >> (m + 1)) - 1 : expv - 1;
        reg_step(500, expv);
      end
    end
    for (int c = 0; c < 4; c++) begin
      increment_step_code = CODE2_W'(c);
      expv = expv + inc[c] > SETTING ? SETTING : expv + inc[c];
      reg_step(10, expv);
    end
    reg_step(10, SETTING);
  endtask : t_floor_and_rise

  task automatic t_disable();
    lower_band_code = 4'h0;
    current_scale_setting = 5'h07;
    repeat (2) @(negedge mclk);
    check("scale", 10'h007, {5'h00, actual_current_scale});
    reg_step(10, 7);
  endtask : t_disable

  initial begin
    load_threshold_offset = 7'h00;
    load_filter_enable    = 1'b0;
    lower_band_code       = 4'h0;
    band_width_code       = 4'h0;
    increment_step_code   = 2'h0;
    decrement_rate_code   = 2'h0;
    min_current_code      = 1'b0;
    current_scale_setting = 5'h14;
    t_reset(10'h014);
    t_offset();
    t_filter();
    t_decrement();
    t_floor_and_rise();
    t_disable();
    t_reset(10'h007);
    report_and_stop();
  end
endmodule : load_adaptive_current_regulator_test
`default_nettype wire
